//--- pss_pkg.sv
// Package for the parameter set sequencer: register map, field layout,
// reset values, control source codes and timing counts.
// Assumes one 200 MHz clock and a plain address/strobe register port.
//
// Notes on behaviour
// - Every accepted trigger samples the enabled advance and restart inputs first.
// - Restart sampled high selects set 0 regardless of the advance input.
// - Advance high without restart loads the next set before acquiring.
// - Advance low without restart acquires again with the current set.
// - Leave the waiting state briefly on input change or set load.
// - Triggers arriving outside the waiting state are discarded.
// - With source disabled, advance only on a software advance command.
// - With source disabled, restart only on a software restart command.
// - Software commands act late; triggers meanwhile use the active set.
// - A software restart loads set 0 into the active set.
// - Disabled source: triggers acquire with the active set, no sampling.
// - Advancing past the last set starts a new cycle, endlessly.
// - Enabling immediately loads set 0, before any trigger.
// - Disabling mid-frame finishes that frame, then stops cycling.
// - Disabling restores the active parameters held before enabling.

package pss_pkg;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SET_TOTAL = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_DISCARD = 8'h10;

  // Control register fields.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ADV_LSB = 1;
  localparam int CTRL_RST_LSB = 4;
  localparam int SRC_W = 3;

  // Command register fields, write one to issue.
  localparam int CMD_ADV_BIT = 0;
  localparam int CMD_RST_BIT = 1;

  // Status register fields.
  localparam int STAT_WAIT_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_PADV_BIT = 2;
  localparam int STAT_PRST_BIT = 3;
  localparam int STAT_IDX_LSB = 8;

  localparam int IDX_W = 6;
  localparam int TOTAL_W = 7;
  localparam int MAX_SETS = 64;
  localparam logic [TOTAL_W-1:0] SET_TOTAL_RST = 7'h01;
  localparam int DISCARD_W = 16;

  // Control source codes; always-active is meaningful for advance only.
  localparam logic [SRC_W-1:0] SRC_DISABLED = 3'h0;
  localparam logic [SRC_W-1:0] SRC_ALWAYS = 3'h1;
  localparam logic [SRC_W-1:0] SRC_LINE_ONE = 3'h2;
  localparam logic [SRC_W-1:0] SRC_CC_ONE = 3'h3;
  localparam logic [SRC_W-1:0] SRC_CC_TWO = 3'h4;
  localparam logic [SRC_W-1:0] SRC_CC_THREE = 3'h5;

  // Timing: settle after an input change and time to load a set.
  localparam int CLK_MHZ = 200;
  localparam int SETTLE_NS = 100;
  localparam int LOAD_NS = 200;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int LOAD_CYC = (LOAD_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_WAIT = 5'h02,
    ST_SETTLE = 5'h04,
    ST_LOAD = 5'h08,
    ST_ACQ = 5'h10
  } pss_state_e;

endpackage

//--- pss_sequencer.sv
// Parameter set sequencer in controlled advance mode: picks which stored
// set becomes active on each frame start trigger.
// Assumes the trigger and control lines are asynchronous pins, frame_done
// comes from the acquisition logic on ref_clk, and set storage acts on
// the load and restore strobes.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps

module pss_sequencer
#(
  parameter int IDX_W = pss_pkg::IDX_W,
  parameter int SETTLE_CYC = pss_pkg::SETTLE_CYC,
  parameter int LOAD_CYC = pss_pkg::LOAD_CYC
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic frame_trig,
  input wire logic line_one,
  input wire logic frame_grabber_control_one,
  input wire logic frame_grabber_control_two,
  input wire logic frame_grabber_control_three,
  input wire logic frame_done,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic waiting_for_trigger,
  output logic seq_running,
  output logic [IDX_W-1:0] active_index,
  output logic set_load,
  output logic active_restore,
  output logic acq_start
);

  localparam int NPIN = 5;
  localparam int SW = pss_pkg::SRC_W;
  localparam int TW = pss_pkg::TOTAL_W;
  localparam int CW = pss_pkg::CNT_W;
  localparam int DW = pss_pkg::DISCARD_W;

  // Returns the level of the chosen control source; pins are synchronised.
  function automatic logic src_level(input logic [SW-1:0] src,
                                     input logic [3:0] lines);
    case (src)
      pss_pkg::SRC_ALWAYS: return 1'b1;
      pss_pkg::SRC_LINE_ONE: return lines[0];
      pss_pkg::SRC_CC_ONE: return lines[1];
      pss_pkg::SRC_CC_TWO: return lines[2];
      pss_pkg::SRC_CC_THREE: return lines[3];
      default: return 1'b0;
    endcase
  endfunction

  // Two-flop synchronisers on every pin, plus a third stage for edges.
  logic [NPIN-1:0] pin_raw, pin_s1, pin_s2, pin_s3;

  assign pin_raw = {frame_grabber_control_three, frame_grabber_control_two,
                    frame_grabber_control_one, line_one, frame_trig};

  generate
    for (genvar g = 0; g < NPIN; g++)
    begin : g_sync
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          pin_s1[g] <= 1'b0;
          pin_s2[g] <= 1'b0;
          pin_s3[g] <= 1'b0;
        end
        else
        begin
          pin_s1[g] <= pin_raw[g];
          pin_s2[g] <= pin_s1[g];
          pin_s3[g] <= pin_s2[g];
        end
      end
    end
  endgenerate

  logic trig_edge;
  logic [3:0] lines_now, lines_old;

  assign trig_edge = pin_s2[0] & ~pin_s3[0];
  assign lines_now = pin_s2[4:1];
  assign lines_old = pin_s3[4:1];

  // Configuration and command state.
  logic enable, next_enable;
  logic [SW-1:0] adv_src, next_adv_src, rst_src, next_rst_src;
  logic [TW-1:0] set_total, next_set_total;
  logic pend_adv, next_pend_adv, pend_rst, next_pend_rst;
  logic [DW-1:0] discard_cnt, next_discard_cnt;
  logic [31:0] next_rdata;

  // Sequencer state.
  pss_pkg::pss_state_e state, next_state;
  logic [IDX_W-1:0] idx, next_idx;
  logic [CW-1:0] cnt, next_cnt;
  logic acq_after, next_acq_after;
  logic next_set_load, next_restore, next_acq_start;

  logic wr_cmd, apply_adv, apply_rst, discard;
  logic [IDX_W-1:0] last_idx, step_idx;
  logic [TW-1:0] total_eff;

  assign wr_cmd = reg_wr && reg_addr == pss_pkg::OFS_CMD;
  assign total_eff = (set_total == '0) ? TW'(1) : set_total;
  assign last_idx = IDX_W'(total_eff - TW'(1));
  // Past the last set the index wraps and a new cycle begins.
  assign step_idx = (idx >= last_idx) ? '0 : idx + IDX_W'(1);

  always_comb
  begin
    next_enable = enable;
    next_adv_src = adv_src;
    next_rst_src = rst_src;
    next_set_total = set_total;
    next_rdata = 32'h0000_0000;
    if (reg_wr && reg_addr == pss_pkg::OFS_CTRL)
    begin
      next_enable = reg_wdata[pss_pkg::CTRL_EN_BIT];
      next_adv_src = reg_wdata[pss_pkg::CTRL_ADV_LSB +: SW];
      next_rst_src = reg_wdata[pss_pkg::CTRL_RST_LSB +: SW];
    end
    if (reg_wr && reg_addr == pss_pkg::OFS_SET_TOTAL)
      next_set_total = reg_wdata[TW-1:0];
    // A command written in the cycle it is consumed is kept pending.
    next_pend_adv = (pend_adv & ~apply_adv)
                  | (wr_cmd & reg_wdata[pss_pkg::CMD_ADV_BIT]);
    next_pend_rst = (pend_rst & ~apply_rst)
                  | (wr_cmd & reg_wdata[pss_pkg::CMD_RST_BIT]);
    next_discard_cnt = discard ? discard_cnt + DW'(1) : discard_cnt;
    if (reg_rd)
    begin
      case (reg_addr)
        pss_pkg::OFS_CTRL:
          next_rdata = {25'h0, rst_src, adv_src, enable};
        pss_pkg::OFS_SET_TOTAL:
          next_rdata = {25'h0, set_total};
        pss_pkg::OFS_STATUS:
        begin
          next_rdata[pss_pkg::STAT_WAIT_BIT] = state == pss_pkg::ST_WAIT;
          next_rdata[pss_pkg::STAT_RUN_BIT] = state != pss_pkg::ST_IDLE;
          next_rdata[pss_pkg::STAT_PADV_BIT] = pend_adv;
          next_rdata[pss_pkg::STAT_PRST_BIT] = pend_rst;
          next_rdata[pss_pkg::STAT_IDX_LSB +: IDX_W] = idx;
        end
        pss_pkg::OFS_DISCARD:
          next_rdata = {16'h0, discard_cnt};
        default:
          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      enable <= 1'b0;
      adv_src <= pss_pkg::SRC_DISABLED;
      rst_src <= pss_pkg::SRC_DISABLED;
      set_total <= pss_pkg::SET_TOTAL_RST;
      pend_adv <= 1'b0;
      pend_rst <= 1'b0;
      discard_cnt <= '0;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      enable <= next_enable;
      adv_src <= next_adv_src;
      rst_src <= next_rst_src;
      set_total <= next_set_total;
      pend_adv <= next_pend_adv;
      pend_rst <= next_pend_rst;
      discard_cnt <= next_discard_cnt;
      reg_rdata <= next_rdata;
    end
  end

  always_comb
  begin
    logic adv_lvl, rst_lvl, sync_mode, watch_change;
    adv_lvl = src_level(adv_src, lines_now);
    rst_lvl = src_level(rst_src, lines_now);
    sync_mode = adv_src != pss_pkg::SRC_DISABLED
             || rst_src != pss_pkg::SRC_DISABLED;
    watch_change = adv_lvl != src_level(adv_src, lines_old)
                || rst_lvl != src_level(rst_src, lines_old);
    next_state = state;
    next_idx = idx;
    next_cnt = (cnt != '0) ? cnt - CW'(1) : cnt;
    next_acq_after = acq_after;
    next_set_load = 1'b0;
    next_restore = 1'b0;
    next_acq_start = 1'b0;
    apply_adv = 1'b0;
    apply_rst = 1'b0;
    discard = trig_edge && state != pss_pkg::ST_WAIT;
    case (state)
      pss_pkg::ST_IDLE:
      begin
        if (enable)
        begin
          // Set 0 goes active at once, before any trigger is seen.
          next_idx = '0;
          next_set_load = 1'b1;
          next_acq_after = 1'b0;
          next_cnt = CW'(LOAD_CYC - 1);
          next_state = pss_pkg::ST_LOAD;
        end
      end
      pss_pkg::ST_WAIT:
      begin
        if (!enable)
        begin
          next_restore = 1'b1;
          next_state = pss_pkg::ST_IDLE;
        end
        else if (trig_edge)
        begin
          // Both inputs are sampled at the trigger; restart wins.
          next_acq_after = 1'b1;
          if (rst_src != pss_pkg::SRC_DISABLED && rst_lvl)
          begin
            next_idx = '0;
            next_set_load = 1'b1;
            next_cnt = CW'(LOAD_CYC - 1);
            next_state = pss_pkg::ST_LOAD;
          end
          else if (adv_src != pss_pkg::SRC_DISABLED && adv_lvl)
          begin
            next_idx = step_idx;
            next_set_load = 1'b1;
            next_cnt = CW'(LOAD_CYC - 1);
            next_state = pss_pkg::ST_LOAD;
          end
          else
          begin
            // Also covers source disabled: acquire with the set as it is.
            next_acq_start = 1'b1;
            next_state = pss_pkg::ST_ACQ;
          end
        end
        else if (rst_src == pss_pkg::SRC_DISABLED && pend_rst)
        begin
          // Software commands only land while waiting, so they may lag.
          apply_rst = 1'b1;
          next_idx = '0;
          next_set_load = 1'b1;
          next_acq_after = 1'b0;
          next_cnt = CW'(LOAD_CYC - 1);
          next_state = pss_pkg::ST_LOAD;
        end
        else if (adv_src == pss_pkg::SRC_DISABLED && pend_adv)
        begin
          apply_adv = 1'b1;
          next_idx = step_idx;
          next_set_load = 1'b1;
          next_acq_after = 1'b0;
          next_cnt = CW'(LOAD_CYC - 1);
          next_state = pss_pkg::ST_LOAD;
        end
        else if (sync_mode && watch_change)
        begin
          next_cnt = CW'(SETTLE_CYC - 1);
          next_state = pss_pkg::ST_SETTLE;
        end
      end
      pss_pkg::ST_SETTLE:
      begin
        if (!enable)
        begin
          next_restore = 1'b1;
          next_state = pss_pkg::ST_IDLE;
        end
        else if (cnt == '0)
          next_state = pss_pkg::ST_WAIT;
      end
      pss_pkg::ST_LOAD:
      begin
        if (cnt == '0)
        begin
          next_acq_start = acq_after;
          next_state = acq_after ? pss_pkg::ST_ACQ : pss_pkg::ST_WAIT;
        end
      end
      pss_pkg::ST_ACQ:
      begin
        // A disable here waits for the frame to finish first.
        if (frame_done)
        begin
          next_restore = !enable;
          next_state = enable ? pss_pkg::ST_WAIT : pss_pkg::ST_IDLE;
        end
      end
      default:
        next_state = pss_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= pss_pkg::ST_IDLE;
      idx <= '0;
      cnt <= '0;
      acq_after <= 1'b0;
      set_load <= 1'b0;
      active_restore <= 1'b0;
      acq_start <= 1'b0;
      active_index <= '0;
      waiting_for_trigger <= 1'b0;
      seq_running <= 1'b0;
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      cnt <= next_cnt;
      acq_after <= next_acq_after;
      set_load <= next_set_load;
      active_restore <= next_restore;
      acq_start <= next_acq_start;
      active_index <= next_idx;
      waiting_for_trigger <= next_state == pss_pkg::ST_WAIT;
      seq_running <= next_state != pss_pkg::ST_IDLE;
    end
  end

endmodule

//--- pss_sva.sv
// Port checker for the parameter set sequencer.
// Assumes a bind onto pss_sequencer with the same parameter values.
`timescale 1ns/1ps

module pss_sva
#(
  parameter int IDX_W = pss_pkg::IDX_W,
  parameter int LOAD_CYC = pss_pkg::LOAD_CYC
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic waiting_for_trigger,
  input wire logic seq_running,
  input wire logic [IDX_W-1:0] active_index,
  input wire logic set_load,
  input wire logic active_restore,
  input wire logic acq_start
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // A start comes from a trigger taken in the waiting state or a load.
  a_acq_has_cause: assert property (
    acq_start |-> $past(waiting_for_trigger) || $past(set_load, LOAD_CYC))
    else $error("acq_start without trigger or load");
  a_acq_no_wait: assert property (
    acq_start |-> !waiting_for_trigger)
    else $error("waiting high at acq_start");
  a_load_no_wait: assert property (
    set_load |-> !waiting_for_trigger [*2])
    else $error("waiting high during set load");
  a_index_by_load: assert property (
    $changed(active_index) |-> set_load)
    else $error("active_index moved without set_load");
  a_load_pulse: assert property (
    set_load |=> !set_load)
    else $error("set_load longer than one cycle");
  a_stop_restores: assert property (
    $fell(seq_running) |-> active_restore)
    else $error("stop without active_restore");
  a_restore_idle: assert property (
    active_restore |-> !seq_running && !acq_start)
    else $error("active_restore while running");
  a_enable_set_zero: assert property (
    $rose(seq_running) |-> set_load && active_index == '0)
    else $error("enable did not load set zero");

  c_load_nonzero: cover property (set_load && active_index != '0);
  c_acq: cover property (acq_start);
  c_restore: cover property (active_restore);
endmodule

//--- pss_far_end.sv
// Far side model: frame trigger source and acquisition back end.
// Assumes the bench requests triggers on fire; frames end after a delay.
`timescale 1ns/1ps

module pss_far_end
(
  input wire logic ref_clk,
  input wire logic fire,
  input wire logic rude,
  input wire logic slow,
  input wire logic waiting_for_trigger,
  input wire logic acq_start,
  output logic frame_trig,
  output logic frame_done
);
  int hi_cnt = 0;
  int done_cnt = 0;
  logic trig_q = 1'b0;
  logic done_q = 1'b0;

  assign frame_trig = trig_q;
  assign frame_done = done_q;

  // Triggers go out only while waiting; rude breaks that on purpose.
  always @(posedge ref_clk)
  begin
    if (fire && (waiting_for_trigger || rude))
    begin
      trig_q <= 1'b1;
      hi_cnt <= 3;
    end
    else if (hi_cnt > 0)
      hi_cnt <= hi_cnt - 1;
    else
      trig_q <= 1'b0;
    if (acq_start)
      done_cnt <= slow ? 30 : 4;
    else if (done_cnt > 0)
      done_cnt <= done_cnt - 1;
    done_q <= (done_cnt == 1);
  end
endmodule

//--- testbench.sv
// Bench for the parameter set sequencer: registers, lines and triggers.
// Assumes pss_far_end as trigger source and pss_sva bound to the design.
`timescale 1ns/1ps

module testbench;
  logic ref_clk, nrst, line_one, fgc1, fgc2, fgc3, fire, rude, slow;
  logic frame_trig, frame_done, reg_wr, reg_rd, waiting_for_trigger;
  logic seq_running, set_load, active_restore, acq_start;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [5:0] active_index, acq_idx;
  int errors = 0;
  int checked = 0;
  int loads = 0;
  int rests = 0;
  int acqs = 0;
  int cyc = 0;

  pss_sequencer #(.SETTLE_CYC(2), .LOAD_CYC(2)) DUT
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .frame_trig(frame_trig),
    .line_one(line_one),
    .frame_grabber_control_one(fgc1),
    .frame_grabber_control_two(fgc2),
    .frame_grabber_control_three(fgc3),
    .frame_done(frame_done),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .waiting_for_trigger(waiting_for_trigger),
    .seq_running(seq_running),
    .active_index(active_index),
    .set_load(set_load),
    .active_restore(active_restore),
    .acq_start(acq_start)
  );

  pss_far_end far
  (
    .ref_clk(ref_clk),
    .fire(fire),
    .rude(rude),
    .slow(slow),
    .waiting_for_trigger(waiting_for_trigger),
    .acq_start(acq_start),
    .frame_trig(frame_trig),
    .frame_done(frame_done)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    loads <= loads + int'(set_load);
    rests <= rests + int'(active_restore);
    acqs <= acqs + int'(acq_start);
    if (acq_start)
      acq_idx <= active_index;
    if (cyc == 9000)
    begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  function automatic logic [31:0] ctrl(input logic [2:0] a,
                                       input logic [2:0] r);
    return {25'h0, r, a, 1'b1};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("reg_rdata", e, reg_rdata);
    @(posedge ref_clk);
  endtask

  task automatic wait_cnt(ref int c, input int c0);
    int n = 0;
    while ((c == c0 || waiting_for_trigger !== 1'b1) && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  // Lines settle and hold a full microsecond around every trigger.
  task automatic set_lines(input logic [1:0] v);
    repeat (200) @(posedge ref_clk);
    line_one <= v[1];
    fgc1 <= v[0];
    repeat (200) @(posedge ref_clk);
  endtask

  task automatic cmd_load(input logic [7:0] a, input logic [31:0] d,
                          input logic [5:0] idx);
    int l0;
    l0 = loads;
    wr(a, d);
    wait_cnt(loads, l0);
    chk("load index", {26'h0, idx}, {26'h0, active_index});
  endtask

  task automatic shot(input logic [5:0] idx, input int dl);
    int l0;
    int a0;
    l0 = loads;
    a0 = acqs;
    wait_cnt(a0, a0 + 1);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    wait_cnt(acqs, a0);
    chk("acq index", {26'h0, idx}, {26'h0, acq_idx});
    chk("loads", 32'(dl), 32'(loads - l0));
  endtask

  task automatic t_sync();
    logic [1:0] lv [6] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3};
    logic [5:0] ix [6] = '{6'h00, 6'h01, 6'h02, 6'h00, 6'h01, 6'h00};
    wr(pss_pkg::OFS_SET_TOTAL, 32'h3);
    cmd_load(pss_pkg::OFS_CTRL, ctrl(3'h2, 3'h3), 6'h00);
    for (int i = 0; i < 6; i++)
    begin
      set_lines(lv[i]);
      shot(ix[i], (i == 0) ? 0 : 1);
    end
  endtask

  task automatic t_discard();
    int a0;
    int l0;
    set_lines(2'h0);
    slow <= 1'b1;
    a0 = acqs;
    l0 = loads;
    wait_cnt(a0, a0 + 1);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    // The second trigger must land while the long frame is still running.
    while (acqs == a0)
      @(posedge ref_clk);
    chk("acq index", 32'h0, {26'h0, acq_idx});
    chk("loads", 32'h0, 32'(loads - l0));
    repeat (3) @(posedge ref_clk);
    rude <= 1'b1;
    fire <= 1'b1;
    @(posedge ref_clk);
    rude <= 1'b0;
    fire <= 1'b0;
    wait_cnt(a0, a0 + 1);
    repeat (8) @(posedge ref_clk);
    chk("acq count", 32'h1, 32'(acqs - a0));
    rd_chk(pss_pkg::OFS_DISCARD, 32'h1);
    slow <= 1'b0;
  endtask

  task automatic t_always();
    wr(pss_pkg::OFS_CTRL, 32'h0);
    cmd_load(pss_pkg::OFS_CTRL, ctrl(3'h1, 3'h4), 6'h00);
    shot(6'h01, 1);
    repeat (200) @(posedge ref_clk);
    fgc2 <= 1'b1;
    repeat (200) @(posedge ref_clk);
    shot(6'h00, 1);
  endtask

  task automatic t_soft();
    int r0;
    int a0;
    int l0;
    r0 = rests;
    wr(pss_pkg::OFS_CTRL, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk("restores", 32'h1, 32'(rests - r0));
    set_lines(2'h3);
    cmd_load(pss_pkg::OFS_CTRL, ctrl(3'h0, 3'h0), 6'h00);
    shot(6'h00, 0);
    cmd_load(pss_pkg::OFS_CMD, 32'h1, 6'h01);
    shot(6'h01, 0);
    cmd_load(pss_pkg::OFS_CMD, 32'h2, 6'h00);
    slow <= 1'b1;
    l0 = loads;
    a0 = acqs;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    // Disable while this long frame runs, so the frame must finish first.
    while (acqs == a0)
      @(posedge ref_clk);
    chk("acq index", 32'h0, {26'h0, acq_idx});
    chk("loads", 32'h0, 32'(loads - l0));
    r0 = rests;
    wr(pss_pkg::OFS_CTRL, 32'h0);
    repeat (5) @(posedge ref_clk);
    chk("early restore", 32'h0, 32'(rests - r0));
    repeat (40) @(posedge ref_clk);
    chk("restores", 32'h1, 32'(rests - r0));
    chk("running", 32'h0, {31'h0, seq_running});
  endtask

  initial
  begin
    nrst = 1'b0;
    {line_one, fgc1, fgc2, fgc3, fire, rude, slow} = 7'h00;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 42'h0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd_chk(pss_pkg::OFS_CTRL, 32'h0);
    rd_chk(pss_pkg::OFS_SET_TOTAL, 32'h1);
    rd_chk(pss_pkg::OFS_STATUS, 32'h0);
    rd_chk(8'h14, 32'h0);
    t_sync();
    t_discard();
    t_always();
    t_soft();
    test_done();
  end
endmodule

bind pss_sequencer pss_sva #(.IDX_W(IDX_W), .LOAD_CYC(LOAD_CYC)) u_sva
(
  .ref_clk(ref_clk),
  .nrst(nrst),
  .waiting_for_trigger(waiting_for_trigger),
  .seq_running(seq_running),
  .active_index(active_index),
  .set_load(set_load),
  .active_restore(active_restore),
  .acq_start(acq_start)
);
